// ### ebt_map.vh
`ifndef EBT_MAP_VH
`define EBT_MAP_VH

// Register indices
`define EBT_REG_CTRL      4'h0
`define EBT_REG_UNIT      4'h1
`define EBT_REG_INDEX     4'h2
`define EBT_REG_COUNT     4'h3
`define EBT_REG_CTLADDR   4'h4
`define EBT_REG_WDOG      4'h5
`define EBT_REG_STATUS    4'h6
`define EBT_REG_IRQ_STAT  4'h7
`define EBT_REG_IRQ_CLR   4'h8
`define EBT_REG_IRQ_EN    4'h9

// Control fields
`define EBT_CTRL_DIR_READ 0
`define EBT_CTRL_WIDE     1
`define EBT_CTRL_PULSE    2
`define EBT_CTRL_PERMIT   3
`define EBT_CTRL_MASTER   4
`define EBT_CTRL_W        5

// Status and interrupt fields
`define EBT_ST_BUSY       0
`define EBT_ST_EXEC       1
`define EBT_ST_SUSP       2
`define EBT_EV_DONE       0
`define EBT_EV_RANGE      1
`define EBT_EV_WDOG       2
`define EBT_EV_ISR_REFUSE 3
`define EBT_EV_W          4

// Operand limits
`define EBT_UNIT_MAX      16'h0007
`define EBT_INDEX_MAX     17'h07ffe
`define EBT_COUNT_MIN     16'h0001
`define EBT_COUNT_MAX     16'h7fff

// Reset values
`define EBT_CTRL_RST      5'h00
`define EBT_WDOG_RST      16'h00c8

// Timing
`define EBT_CLK_NS        20
`define EBT_WDOG_UNIT_NS  1000000
`define EBT_WDOG_TICK_CYC (`EBT_WDOG_UNIT_NS / `EBT_CLK_NS)

`endif

// ### ebt_sync3.v
`timescale 1ns/10ps
module ebt_sync3 #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         rst_b,
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);
  reg [W-1:0] s1Q;
  reg [W-1:0] s2Q;
  reg [W-1:0] s3Q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          s1Q[i]     <= 1'b0;
          s2Q[i]     <= 1'b0;
          s3Q[i]     <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          s1Q[i] <= asyncIn[i];
          s2Q[i] <= s1Q[i];
          s3Q[i] <= s2Q[i];
          // Change counts only once two stages agree
          if (s2Q[i] == s3Q[i])
            syncOut[i] <= s3Q[i];
        end
      end
    end
  endgenerate
endmodule

// ### ebt_unit_mem.sv
`timescale 1ns/10ps
module ebt_unit_mem (
  input  wire         ref_clk,
  input  wire  [7:0]  unitSel,
  input  wire         masterSel,
  input  wire  [14:0] bufAddr,
  input  wire  [15:0] bufWrData,
  input  wire         bufWr,
  input  wire         bufRd,
  output logic [15:0] bufRdData,
  input  wire  [15:0] ctlAddr,
  input  wire  [15:0] ctlWrData,
  input  wire         ctlWr,
  input  wire         ctlRd,
  output logic [15:0] ctlRdData
);
  logic [15:0] bufMem [int];
  logic [15:0] ctlMem [int];
  initial
  begin
    bufRdData = 16'h0;
    ctlRdData = 16'h0;
  end
  wire [23:0] bufKey = {masterSel, unitSel, bufAddr};
  // Undriven cycles toggle so stale data never looks valid
  // Unwritten words read as zero, never unknown
  always @(posedge ref_clk)
  begin
    if (bufRd)
      bufRdData <= bufMem.exists(bufKey) ? bufMem[bufKey] : 16'h0;
    else
      bufRdData <= ~bufRdData;
    if (ctlRd)
      ctlRdData <= ctlMem.exists(ctlAddr) ? ctlMem[ctlAddr] : 16'h0;
    else
      ctlRdData <= ~ctlRdData;
    if (bufWr)
      bufMem[bufKey] = bufWrData;
    if (ctlWr)
      ctlMem[ctlAddr] = ctlWrData;
  end
endmodule

// ### ebt_watchdog.v
`timescale 1ns/10ps
`include "ebt_map.vh"
module ebt_watchdog #(
  parameter TICK_CYC = `EBT_WDOG_TICK_CYC
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        kick,
  input  wire        periodWr,
  input  wire [15:0] period,
  output reg         expired
);
  reg [31:0] divQ;
  reg [15:0] elapsedQ;
  reg        firedQ;
  wire       tick = (divQ == TICK_CYC - 1);

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divQ     <= 32'h0;
      elapsedQ <= 16'h0;
      firedQ   <= 1'b0;
      expired  <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      // New period restarts monitoring from now
      if (kick || periodWr)
      begin
        divQ     <= 32'h0;
        elapsedQ <= 16'h0;
        firedQ   <= 1'b0;
      end
      else
      begin
        divQ <= tick ? 32'h0 : divQ + 32'h1;
        if (tick && elapsedQ != 16'hffff)
          elapsedQ <= elapsedQ + 16'h1;
        // One report per overrun, not per tick
        if (!firedQ && elapsedQ >= period && period != 16'h0)
        begin
          expired <= 1'b1;
          firedQ  <= 1'b1;
        end
      end
    end
  end
endmodule

// ### ebt_xfer_engine.v
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "ebt_map.vh"
module ebt_xfer_engine #(
  parameter WDOG_TICK_CYC = `EBT_WDOG_TICK_CYC
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdData,
  input  wire        execCond,
  input  wire        scanStrobe,
  output reg         exec_state_out,
  input  wire        irqReq,
  input  wire        inIsr,
  input  wire        isrDone,
  output reg         irqGrant,
  output wire        irqOut,
  input  wire [7:0]  unitPresent,
  output reg  [7:0]  unitSel,
  output reg         masterSel,
  output reg  [14:0] bufAddr,
  output reg  [15:0] bufWrData,
  output wire        bufWr,
  output wire        bufRd,
  input  wire [15:0] bufRdData,
  output reg  [15:0] ctlAddr,
  output reg  [15:0] ctlWrData,
  output wire        ctlWr,
  output wire        ctlRd,
  input  wire [15:0] ctlRdData
);
  localparam S_IDLE  = 5'b00001;
  localparam S_FETCH = 5'b00010;
  localparam S_MOVE  = 5'b00100;
  localparam S_WRITE = 5'b01000;
  localparam S_SUSP  = 5'b10000;

  reg  [`EBT_CTRL_W-1:0] ctrlQ;
  reg  [15:0]            unitQ;
  reg  [15:0]            indexQ;
  reg  [15:0]            countQ;
  reg  [15:0]            ctlBaseQ;
  reg  [15:0]            wdogPeriodQ;
  reg  [`EBT_EV_W-1:0]   irqStatQ;
  reg  [`EBT_EV_W-1:0]   irqStatD;
  reg  [`EBT_EV_W-1:0]   irqEnQ;
  reg  [4:0]             stateQ;
  reg                    dirReadQ;
  reg  [15:0]            wordsLeftQ;
  reg                    condPrevQ;
  reg                    irqPendQ;
  wire [7:0]             presentSync;
  wire                   wdogExpired;

  wire permit   = ctrlQ[`EBT_CTRL_PERMIT];
  wire wide     = ctrlQ[`EBT_CTRL_WIDE];
  wire isWr     = regWr && regAddr == `EBT_REG_WDOG;

  // Continuous form keys on scan, pulse form on rising condition
  wire trigger = ctrlQ[`EBT_CTRL_PULSE] ? (execCond && !condPrevQ)
                                        : (execCond && scanStrobe);

  // Locate the n-th present unit in physical order
  function [7:0] nth_present;
    input [7:0] present;
    input [2:0] n;
    integer     k;
    reg   [3:0] seen;
    begin
      nth_present = 8'h0;
      seen        = 4'h0;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (present[k])
        begin
          if (seen == {1'b0, n})
            nth_present = 8'h1 << k;
          seen = seen + 4'h1;
        end
      end
    end
  endfunction

  wire        masterHit = ctrlQ[`EBT_CTRL_MASTER] && unitQ == 16'h0;
  wire [2:0]  extNum    = ctrlQ[`EBT_CTRL_MASTER] ? unitQ[2:0] - 3'h1
                                                  : unitQ[2:0];
  wire [7:0]  unitHot   = masterHit ? 8'h0 : nth_present(presentSync, extNum);
  wire [16:0] wordTotal = wide ? {countQ, 1'b0} : {1'b0, countQ};
  wire [16:0] lastIndex = {1'b0, indexQ} + wordTotal - 17'h1;
  wire        unitOk    = unitQ <= `EBT_UNIT_MAX
                          && (masterHit || unitHot != 8'h0);
  wire        countOk   = countQ >= `EBT_COUNT_MIN
                          && countQ <= `EBT_COUNT_MAX;
  wire        indexOk   = {1'b0, indexQ} <= `EBT_INDEX_MAX
                          && lastIndex <= `EBT_INDEX_MAX;
  wire        operandOk = unitOk && countOk && indexOk;
  // A routine may only start a transfer when interrupts are held off
  wire        isrRefuse = permit && inIsr;
  wire        startOk   = (stateQ == S_IDLE) && trigger && operandOk && !isrRefuse;
  wire        lastWord  = wordsLeftQ == 16'h1;
  wire        wordEnd   = stateQ == S_WRITE;
  wire        finish    = wordEnd && lastWord;
  wire        suspendGo = wordEnd && !lastWord && permit && irqPendQ;

  // Strobes follow state; addresses and data are registered
  assign ctlRd = (stateQ == S_FETCH) && !dirReadQ;
  assign bufRd = (stateQ == S_FETCH) && dirReadQ;
  assign bufWr = (stateQ == S_WRITE) && !dirReadQ;
  assign ctlWr = (stateQ == S_WRITE) && dirReadQ;
  assign irqOut = |(irqStatQ & irqEnQ);

  ebt_sync3 #(
    .W (8)
  ) u_present_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (unitPresent),
    .syncOut (presentSync)
  );

  ebt_watchdog #(
    .TICK_CYC (WDOG_TICK_CYC)
  ) u_watchdog (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .kick     (scanStrobe),
    .periodWr (isWr),
    .period   (wdogPeriodQ),
    .expired  (wdogExpired)
  );

  // Sticky events; a new event beats a clear in the same cycle
  always @*
  begin
    irqStatD = irqStatQ;
    if (regWr && regAddr == `EBT_REG_IRQ_CLR)
      irqStatD = irqStatD & ~regWrData[`EBT_EV_W-1:0];
    if (finish)
      irqStatD[`EBT_EV_DONE] = 1'b1;
    if (stateQ == S_IDLE && trigger && !operandOk)
      irqStatD[`EBT_EV_RANGE] = 1'b1;
    if (wdogExpired)
      irqStatD[`EBT_EV_WDOG] = 1'b1;
    if (stateQ == S_IDLE && trigger && operandOk && isrRefuse)
      irqStatD[`EBT_EV_ISR_REFUSE] = 1'b1;
  end

  // Register writes
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrlQ       <= `EBT_CTRL_RST;
      unitQ       <= 16'h0;
      indexQ      <= 16'h0;
      countQ      <= 16'h0;
      ctlBaseQ    <= 16'h0;
      wdogPeriodQ <= `EBT_WDOG_RST;
      irqEnQ      <= 4'h0;
      irqStatQ    <= 4'h0;
    end
    else
    begin
      irqStatQ <= irqStatD;
      if (regWr)
      begin
        case (regAddr)
          `EBT_REG_CTRL:    ctrlQ       <= regWrData[`EBT_CTRL_W-1:0];
          `EBT_REG_UNIT:    unitQ       <= regWrData;
          `EBT_REG_INDEX:   indexQ      <= regWrData;
          `EBT_REG_COUNT:   countQ      <= regWrData;
          `EBT_REG_CTLADDR: ctlBaseQ    <= regWrData;
          `EBT_REG_WDOG:    wdogPeriodQ <= regWrData;
          `EBT_REG_IRQ_EN:  irqEnQ      <= regWrData[`EBT_EV_W-1:0];
          default:          irqEnQ      <= irqEnQ;
        endcase
      end
    end
  end

  // Register reads, data valid the cycle after the strobe
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 16'h0;
    else if (regRd)
    begin
      case (regAddr)
        `EBT_REG_CTRL:     regRdData <= {11'h0, ctrlQ};
        `EBT_REG_UNIT:     regRdData <= unitQ;
        `EBT_REG_INDEX:    regRdData <= indexQ;
        `EBT_REG_COUNT:    regRdData <= countQ;
        `EBT_REG_CTLADDR:  regRdData <= ctlBaseQ;
        `EBT_REG_WDOG:     regRdData <= wdogPeriodQ;
        `EBT_REG_STATUS:   regRdData <= {13'h0, stateQ == S_SUSP, exec_state_out,
                                         stateQ != S_IDLE};
        `EBT_REG_IRQ_STAT: regRdData <= {12'h0, irqStatQ};
        default:           regRdData <= 16'h0;
      endcase
    end
    else
      regRdData <= 16'h0;
  end

  // Transfer engine: fetch, capture, store, one word per three cycles
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateQ         <= S_IDLE;
      dirReadQ       <= 1'b0;
      wordsLeftQ     <= 16'h0;
      bufAddr        <= 15'h0;
      bufWrData      <= 16'h0;
      ctlAddr        <= 16'h0;
      ctlWrData      <= 16'h0;
      unitSel        <= 8'h0;
      masterSel      <= 1'b0;
      condPrevQ      <= 1'b0;
      exec_state_out <= 1'b0;
    end
    else
    begin
      condPrevQ <= execCond;
      if (!execCond)
        exec_state_out <= 1'b0;
      case (stateQ)
        S_IDLE:
        begin
          if (startOk)
          begin
            stateQ     <= S_FETCH;
            dirReadQ   <= ctrlQ[`EBT_CTRL_DIR_READ];
            wordsLeftQ <= wordTotal[15:0];
            bufAddr    <= indexQ[14:0];
            ctlAddr    <= ctlBaseQ;
            unitSel    <= unitHot;
            masterSel  <= masterHit;
          end
          else if (trigger)
            exec_state_out <= 1'b0;
        end
        S_FETCH:
          stateQ <= S_MOVE;
        S_MOVE:
        begin
          bufWrData <= ctlRdData;
          ctlWrData <= bufRdData;
          stateQ    <= S_WRITE;
        end
        S_WRITE:
        begin
          // Consecutive indices keep low half before high half
          wordsLeftQ <= wordsLeftQ - 16'h1;
          if (dirReadQ)
            bufAddr <= bufAddr + 15'h1;
          else
            bufAddr <= bufAddr + 15'h1;
          ctlAddr <= ctlAddr + 16'h1;
          if (finish)
          begin
            stateQ         <= S_IDLE;
            unitSel        <= 8'h0;
            masterSel      <= 1'b0;
            exec_state_out <= execCond;
          end
          else if (suspendGo)
            stateQ <= S_SUSP;
          else
            stateQ <= S_FETCH;
        end
        S_SUSP:
        begin
          if (isrDone)
            stateQ <= S_FETCH;
        end
        default:
          stateQ <= S_IDLE;
      endcase
    end
  end

  // Interrupt arbitration against the transfer
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqPendQ <= 1'b0;
      irqGrant <= 1'b0;
    end
    else
    begin
      irqGrant <= 1'b0;
      if (irqPendQ && (finish || suspendGo
                       || (stateQ == S_IDLE && !startOk)))
      begin
        irqGrant <= 1'b1;
        irqPendQ <= irqReq;
      end
      else if (irqReq)
        irqPendQ <= 1'b1;
    end
  end
endmodule

// ### ebt_xfer_engine_sva.sv
`timescale 1ns/10ps
module ebt_xfer_engine_sva (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        regRd,
  input wire [15:0] regRdData,
  input wire        execCond,
  input wire        exec_state_out,
  input wire        irqGrant,
  input wire [7:0]  unitSel,
  input wire        masterSel,
  input wire [15:0] bufWrData,
  input wire        bufWr,
  input wire        bufRd,
  input wire [15:0] bufRdData,
  input wire [15:0] ctlWrData,
  input wire        ctlWr,
  input wire        ctlRd,
  input wire [15:0] ctlRdData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_rd_quiet: assert property (!$past(regRd) |-> regRdData == 16'h0)
    else $error("read data outside read answer");
  chk_unit_onehot: assert property ($onehot0(unitSel) && !(masterSel && unitSel != 8'h0))
    else $error("more than one unit selected");
  chk_bus_select: assert property ((bufWr || bufRd) |-> (unitSel != 8'h0 || masterSel))
    else $error("buffer access without a unit");
  chk_write_order: assert property (ctlRd |-> ##2 bufWr)
    else $error("write move out of order");
  chk_read_order: assert property (bufRd |-> ##2 ctlWr)
    else $error("read move out of order");
  chk_write_data: assert property (bufWr |-> bufWrData == $past(ctlRdData))
    else $error("buffer data not the fetched word");
  chk_read_data: assert property (ctlWr |-> ctlWrData == $past(bufRdData))
    else $error("controller data not the fetched word");
  chk_done_after: assert property ($rose(exec_state_out) |-> $past(bufWr || ctlWr))
    else $error("done without a final move");
  chk_exec_low: assert property (!execCond [*2] |-> !exec_state_out)
    else $error("exec state high without condition");
  cover property (bufWr);
  cover property (ctlWr);
  cover property (irqGrant);
  cover property ($rose(exec_state_out) && $past(masterSel));
endmodule

// ### extension_buffer_transfer_tb_top.sv
`timescale 1ns/10ps
`include "ebt_map.vh"
module extension_buffer_transfer_tb_top;
  logic        ref_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0;
  logic        execCond = 1'b0, scanStrobe = 1'b0, irqReq = 1'b0, inIsr = 1'b0, isrDone = 1'b0;
  logic [7:0]  unitPresent = 8'ha6;
  wire         exec_state_out, irqGrant, irqOut, masterSel, bufWr, bufRd, ctlWr, ctlRd;
  wire  [7:0]  unitSel;
  wire  [14:0] bufAddr;
  wire  [15:0] regRdData, bufWrData, bufRdData, ctlAddr, ctlWrData, ctlRdData;
  int          errors = 0, tests_run = 0, grants = 0, moves = 0;
  ebt_xfer_engine #(.WDOG_TICK_CYC(4)) u_dut (.ref_clk, .rst_b, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .execCond, .scanStrobe, .exec_state_out, .irqReq, .inIsr, .isrDone,
    .irqGrant, .irqOut, .unitPresent, .unitSel, .masterSel, .bufAddr, .bufWrData, .bufWr,
    .bufRd, .bufRdData, .ctlAddr, .ctlWrData, .ctlWr, .ctlRd, .ctlRdData);
  ebt_unit_mem u_mem (.ref_clk, .unitSel, .masterSel, .bufAddr, .bufWrData, .bufWr, .bufRd,
    .bufRdData, .ctlAddr, .ctlWrData, .ctlWr, .ctlRd, .ctlRdData);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    grants += irqGrant;
    moves += (bufWr || ctlWr);
  end
  task automatic finish_test();
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge ref_clk);
  endtask
  // 0 interrupt request, 1 routine done, 2 scan strobe
  task automatic pulse(input int which);
    @(posedge ref_clk);
    irqReq <= (which == 0);
    isrDone <= (which == 1);
    scanStrobe <= (which == 2);
    @(posedge ref_clk);
    irqReq <= 1'b0;
    isrDone <= 1'b0;
    scanStrobe <= 1'b0;
  endtask
  task automatic xfer(input logic [4:0] ctrl, input int unit, idx, cnt, base);
    execCond <= 1'b0;
    moves = 0;
    grants = 0;
    wr(`EBT_REG_CTRL, {11'h0, ctrl});
    wr(`EBT_REG_UNIT, unit[15:0]);
    wr(`EBT_REG_INDEX, idx[15:0]);
    wr(`EBT_REG_COUNT, cnt[15:0]);
    wr(`EBT_REG_CTLADDR, base[15:0]);
    @(posedge ref_clk);
    execCond <= 1'b1;
    scanStrobe <= ~ctrl[`EBT_CTRL_PULSE];
    @(posedge ref_clk);
    scanStrobe <= 1'b0;
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    while (exec_state_out !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 400)
    begin
      errors++;
      $display("CHECK FAILED at %0t: transfer hung", $time);
      finish_test();
    end
  endtask
  // Expected slot key: master first, then present slots in physical order
  function automatic int key(input int unit, input logic master);
    if (master && unit == 0)
      return 32'h800000;
    unit -= master;
    for (int s = 0; s < 8; s++)
      if (unitPresent[s])
      begin
        if (unit == 0)
          return 1 << (s + 15);
        unit--;
      end
    return -1;
  endfunction
  task automatic run(input logic [4:0] ctrl, input int unit, idx, cnt, base);
    logic [15:0] q[$];
    int          k;
    int          w;
    k = key(unit, ctrl[`EBT_CTRL_MASTER]);
    w = ctrl[`EBT_CTRL_WIDE] ? 2 * cnt : cnt;
    for (int i = 0; i < w; i++)
    begin
      q.push_back(16'($urandom));
      if (ctrl[`EBT_CTRL_DIR_READ])
        u_mem.bufMem[k + idx + i] = q[i];
      else
        u_mem.ctlMem[base + i] = q[i];
    end
    xfer(ctrl, unit, idx, cnt, base);
    waitDone();
    cyc(6);
    chk(16'(moves), 16'(w));
    for (int i = 0; i < w; i++)
      chk(ctrl[0] ? u_mem.ctlMem[base + i] : u_mem.bufMem[k + idx + i], q[i]);
    execCond <= 1'b0;
    rd(`EBT_REG_IRQ_STAT, 16'h0001);
    wr(`EBT_REG_IRQ_CLR, 16'h000f);
  endtask
  initial
  begin
    int bad[5][3];
    bad = '{'{8, 0, 1}, '{0, 0, 0}, '{0, 0, 32768}, '{0, 32766, 2}, '{4, 0, 1}};
    void'($urandom(32'h5581e942));
    cyc(2);
    rst_b <= 1'b1;
    cyc(5);
    rd(`EBT_REG_WDOG, `EBT_WDOG_RST);
    wr(`EBT_REG_WDOG, 16'h0);
    rd(4'hf, 16'h0);
    run(5'h00, 0, $urandom_range(0, 99), 3, 16'h100);
    run(5'h07, 2, 32763, 2, 16'h200);
    run(5'h14, 0, 7, 1, 16'h300);
    run(5'h13, 1, 9, 2, 16'h400);
    inIsr <= 1'b1;
    run(5'h04, 3, 20, 2, 16'h500);
    xfer(5'h0c, 3, 20, 2, 16'h500);
    cyc(6);
    rd(`EBT_REG_IRQ_STAT, 16'h0008);
    chk(16'(moves), 16'h0);
    inIsr <= 1'b0;
    wr(`EBT_REG_IRQ_CLR, 16'h000f);
    foreach (bad[i])
    begin
      xfer(5'h04, bad[i][0], bad[i][1], bad[i][2], 0);
      cyc(6);
      rd(`EBT_REG_IRQ_STAT, 16'h0002);
      chk(16'(moves), 16'h0);
      wr(`EBT_REG_IRQ_CLR, 16'h000f);
    end
    xfer(5'h00, 0, 50, 1, 16'h600);
    waitDone();
    pulse(2);
    cyc(6);
    chk(16'(moves), 16'h2);
    xfer(5'h04, 0, 50, 1, 16'h600);
    waitDone();
    pulse(2);
    cyc(6);
    chk(16'(moves), 16'h1);
    wr(`EBT_REG_IRQ_CLR, 16'h000f);
    wr(`EBT_REG_IRQ_EN, 16'h0001);
    chk({15'h0, irqOut}, 16'h0);
    xfer(5'h00, 1, 0, 4, 0);
    pulse(0);
    cyc(3);
    chk(16'(grants), 16'h0);
    waitDone();
    cyc(2);
    chk(16'(grants), 16'h1);
    chk({15'h0, irqOut}, 16'h1);
    wr(`EBT_REG_IRQ_EN, 16'h0);
    cyc(1);
    chk({15'h0, irqOut}, 16'h0);
    wr(`EBT_REG_IRQ_CLR, 16'h000f);
    xfer(5'h08, 1, 0, 4, 0);
    pulse(0);
    cyc(6);
    chk(16'(grants), 16'h1);
    rd(`EBT_REG_STATUS, 16'h0005);
    pulse(1);
    waitDone();
    cyc(2);
    chk(16'(moves), 16'h4);
    execCond <= 1'b0;
    wr(`EBT_REG_IRQ_CLR, 16'h000f);
    wr(`EBT_REG_WDOG, 16'h0003);
    cyc(4);
    rd(`EBT_REG_IRQ_STAT, 16'h0000);
    cyc(14);
    rd(`EBT_REG_IRQ_STAT, 16'h0004);
    finish_test();
  end
endmodule
bind ebt_xfer_engine ebt_xfer_engine_sva u_sva (.ref_clk, .rst_b, .regRd, .regRdData, .execCond,
  .exec_state_out, .irqGrant, .unitSel, .masterSel, .bufWrData, .bufWr, .bufRd, .bufRdData,
  .ctlWrData, .ctlWr, .ctlRd, .ctlRdData);
